//--- rtl/eisc_cond.sv
// E1 signalling mode and fault conditioning of timeslots in both directions
// Notes on behaviour
// - With CAS enabled the framer runs in CAS multiframe mode and timeslots carry ABCD signalling.
// - With CAS disabled the framer leaves CAS multiframe mode and no signalling is carried.
// - After reset the signalling mode is CAS enabled so the framer starts in CAS multiframe.
// - An 8-bit conditioning byte, FF after reset, replaces data toward the packet path on LOS, LOF or AIS.
// - The conditioning byte replaces data of used timeslots toward the E1 line on packet buffer overrun or underrun.
// - In unframed mode conditioning becomes AIS, triggered by LOS or by a buffer fault.
// - A 4-bit ABCD pattern, 1 to F and 1 after reset, replaces signalling toward the packet path on LOS, LOF or AIS.
// - The ABCD pattern replaces signalling of used timeslots toward the E1 line on buffer overrun or underrun.
// - In unframed mode the framer is transparent and signalling and conditioning settings do not apply.
// - AIS is sent toward the E1 equipment as an unframed stream of all ones.
// - In framed modes unused timeslots toward the E1 line carry the idle code, 7E after reset.
module eisc_cond
  import eisc_pkg::*;
(
  input  wire logic          MCLK,
  input  wire logic          RESET_N,
  input  wire logic          LCLK,
  input  wire logic          CFG_LOAD,
  input  wire eisc_cfg_type  CFG_IN,
  input  wire logic          LINE_LOS,
  input  wire logic          LINE_LOF,
  input  wire logic          LINE_AIS,
  input  wire logic          BUF_OVERRUN,
  input  wire logic          BUF_UNDERRUN,
  input  wire eisc_slot_type LINE_RX_SLOT,
  input  wire eisc_slot_type PKT_RX_SLOT,
  input  wire logic          PKT_RX_USED,
  output      eisc_slot_type PKT_TX_SLOT,
  output      eisc_slot_type LINE_TX_SLOT,
  output      logic          LINE_TX_AIS,
  output      logic          COND_TO_PKT,
  output      logic          COND_TO_LINE,
  output      eisc_cfg_type  CFG_OUT,
  output      logic          FRM_CAS_MF,
  output      logic          FRM_TRANSPARENT
);

  ////////////////////////////////////////////////////////////////////////////
  // Conditioning of one timeslot; shared by both directions

  function automatic eisc_slot_type cond_slot(
    input eisc_cfg_type  cfg,
    input eisc_slot_type slot,
    input logic          framed_fault,
    input logic          unframed_fault,
    input logic          used
  );
    eisc_slot_type o;
    o = slot;
    if (cfg.unframed)
    begin
      if (unframed_fault)
        o.data = EISC_AIS_BYTE;
      o.abcd = EISC_ABCD_NONE;
    end
    else
    begin
      if (!used)
        o.data = cfg.idle_code;
      else if (framed_fault)
      begin
        o.data = cfg.cond_byte;
        o.abcd = cfg.cond_abcd;
      end
      if (!cfg.cas_en)
        o.abcd = EISC_ABCD_NONE;
    end
    return o;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // System clock domain

  typedef struct packed {
    eisc_cfg_type  cfg;
    eisc_slot_type pkt_tx;
    eisc_slot_type line_tx;
    logic          line_ais;
    logic          cond_pkt;
    logic          cond_line;
  } eisc_main_state_type;

  localparam eisc_main_state_type EISC_MAIN_RST = '{
    cfg:       EISC_CFG_RST,
    pkt_tx:    EISC_SLOT_RST,
    line_tx:   EISC_SLOT_RST,
    line_ais:  1'b0,
    cond_pkt:  1'b0,
    cond_line: 1'b0
  };

  eisc_main_state_type st_q;
  eisc_main_state_type st_d;
  logic [2:0]          line_flt_s;
  logic                line_fault;
  logic                los_fault;
  logic                buf_fault;

  // Line alarms come from the framer pins, so they are synchronised first
  eisc_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h0)
  ) u_line_sync (
    .clk      (MCLK),
    .reset_n  (RESET_N),
    .async_in ({LINE_LOS, LINE_LOF, LINE_AIS}),
    .sync_out (line_flt_s)
  );

  assign los_fault  = line_flt_s[2];
  assign line_fault = |line_flt_s;
  assign buf_fault  = BUF_OVERRUN | BUF_UNDERRUN;

  always_comb
  begin
    st_d = st_q;
    if (CFG_LOAD)
    begin
      st_d.cfg = CFG_IN;
      // ABCD of zero is outside the settable range; keep the old pattern
      if (CFG_IN.cond_abcd == EISC_ABCD_NONE)
        st_d.cfg.cond_abcd = st_q.cfg.cond_abcd;
    end
    // Evaluated with the held setup, so a load takes effect on the next slot
    st_d.pkt_tx    = cond_slot(st_q.cfg, LINE_RX_SLOT, line_fault, los_fault, 1'b1);
    st_d.line_tx   = cond_slot(st_q.cfg, PKT_RX_SLOT, buf_fault, buf_fault,
                               PKT_RX_USED);
    st_d.line_ais  = st_q.cfg.unframed & buf_fault;
    st_d.cond_pkt  = st_q.cfg.unframed ? los_fault : line_fault;
    st_d.cond_line = buf_fault;
  end

  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      st_q <= EISC_MAIN_RST;
    else
      st_q <= st_d;
  end

  assign PKT_TX_SLOT  = st_q.pkt_tx;
  assign LINE_TX_SLOT = st_q.line_tx;
  assign LINE_TX_AIS  = st_q.line_ais;
  assign COND_TO_PKT  = st_q.cond_pkt;
  assign COND_TO_LINE = st_q.cond_line;
  assign CFG_OUT      = st_q.cfg;

  ////////////////////////////////////////////////////////////////////////////
  // Link clock domain: framer mode controls

  typedef struct packed {
    logic cas_mf;
    logic transparent;
  } eisc_link_state_type;

  eisc_link_state_type lk_q;
  eisc_link_state_type lk_d;
  logic [1:0]          mode_s;

  // Mode bits are quasi-static levels, so a per-bit two-flop crossing suffices
  eisc_sync #(
    .WIDTH   (2),
    .RST_VAL ({EISC_CAS_EN_RST, EISC_UNFRAMED_RST})
  ) u_mode_sync (
    .clk      (LCLK),
    .reset_n  (RESET_N),
    .async_in ({st_q.cfg.cas_en, st_q.cfg.unframed}),
    .sync_out (mode_s)
  );

  always_comb
  begin
    lk_d             = lk_q;
    lk_d.transparent = mode_s[0];
    lk_d.cas_mf      = mode_s[1] & ~mode_s[0];
  end

  always_ff @(posedge LCLK or negedge RESET_N)
  begin
    if (!RESET_N)
      lk_q <= '{cas_mf: EISC_CAS_EN_RST, transparent: EISC_UNFRAMED_RST};
    else
      lk_q <= lk_d;
  end

  assign FRM_CAS_MF      = lk_q.cas_mf;
  assign FRM_TRANSPARENT = lk_q.transparent;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb_main @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  chk_pkt_cond_byte: assert property (
    !st_q.cfg.unframed && line_fault && !CFG_LOAD
    |=> PKT_TX_SLOT.data == $past(st_q.cfg.cond_byte))
    else $error("packet side lost conditioning byte on line fault");

  chk_line_cond_byte: assert property (
    !st_q.cfg.unframed && buf_fault && PKT_RX_USED
    |=> LINE_TX_SLOT.data == $past(st_q.cfg.cond_byte))
    else $error("line side lost conditioning byte on buffer fault");

  chk_unframed_ais: assert property (
    st_q.cfg.unframed && buf_fault |=> LINE_TX_AIS && LINE_TX_SLOT.data == EISC_AIS_BYTE)
    else $error("unframed buffer fault did not send AIS");

  chk_pkt_abcd_cond: assert property (
    !st_q.cfg.unframed && st_q.cfg.cas_en && line_fault
    |=> PKT_TX_SLOT.abcd == $past(st_q.cfg.cond_abcd))
    else $error("packet side lost ABCD pattern on line fault");

  chk_abcd_range: assert property (
    CFG_OUT.cond_abcd != EISC_ABCD_NONE)
    else $error("ABCD pattern left its range");

  chk_line_abcd_cond: assert property (
    !st_q.cfg.unframed && st_q.cfg.cas_en && buf_fault && PKT_RX_USED
    |=> LINE_TX_SLOT.abcd == $past(st_q.cfg.cond_abcd))
    else $error("line side lost ABCD pattern on buffer fault");

  chk_no_sig_cas_off: assert property (
    !st_q.cfg.cas_en |=> PKT_TX_SLOT.abcd == EISC_ABCD_NONE)
    else $error("signalling carried with CAS disabled");

  chk_idle_fill: assert property (
    !st_q.cfg.unframed && !PKT_RX_USED
    |=> LINE_TX_SLOT.data == $past(st_q.cfg.idle_code))
    else $error("unused timeslot not filled with idle code");

  chk_resume_data: assert property (
    !line_fault && !st_q.cfg.unframed ##1 !line_fault && !st_q.cfg.unframed
    |-> PKT_TX_SLOT.data == $past(LINE_RX_SLOT.data))
    else $error("packet data not resumed after fault cleared");

  // Four link edges cover both crossing flops and the mode register
  chk_cas_mf_mode: assert property (@(posedge LCLK) disable iff (!RESET_N)
    (st_q.cfg.cas_en && !st_q.cfg.unframed)[*4] |-> FRM_CAS_MF)
    else $error("framer not in CAS multiframe with CAS enabled");

  chk_cas_mf_off: assert property (@(posedge LCLK) disable iff (!RESET_N)
    (!st_q.cfg.cas_en || st_q.cfg.unframed)[*4] |-> !FRM_CAS_MF)
    else $error("framer left in CAS multiframe with CAS disabled");

  chk_transparent: assert property (@(posedge LCLK) disable iff (!RESET_N)
    (st_q.cfg.unframed)[*4] |-> FRM_TRANSPARENT)
    else $error("framer not transparent in unframed mode");

  cov_line_fault: cover property (!st_q.cfg.unframed && line_fault ##1 !line_fault);
  cov_buf_fault:  cover property (!st_q.cfg.unframed && buf_fault ##1 !buf_fault);
  cov_unframed:   cover property (st_q.cfg.unframed && buf_fault);
  cov_cas_off:    cover property (CFG_LOAD && !CFG_IN.cas_en);

endmodule // eisc_cond

//--- rtl/eisc_pkg.sv
// Shared constants and carrier types for the E1 signalling and conditioning block
package eisc_pkg;

  // Values after reset
  localparam logic       EISC_CAS_EN_RST    = 1'b1;
  localparam logic       EISC_UNFRAMED_RST  = 1'b0;
  localparam logic [7:0] EISC_COND_BYTE_RST = 8'hff;
  localparam logic [3:0] EISC_COND_ABCD_RST = 4'h1;
  localparam logic [7:0] EISC_IDLE_CODE_RST = 8'h7e;

  // Fixed codes
  localparam logic [7:0] EISC_AIS_BYTE      = 8'hff;
  localparam logic [3:0] EISC_ABCD_NONE     = 4'h0;

  // Synchroniser depth in cycles
  localparam int         EISC_SYNC_STAGES   = 2;

  typedef struct packed {
    logic       cas_en;
    logic       unframed;
    logic [7:0] cond_byte;
    logic [3:0] cond_abcd;
    logic [7:0] idle_code;
  } eisc_cfg_type;

  localparam eisc_cfg_type EISC_CFG_RST = '{
    cas_en:    EISC_CAS_EN_RST,
    unframed:  EISC_UNFRAMED_RST,
    cond_byte: EISC_COND_BYTE_RST,
    cond_abcd: EISC_COND_ABCD_RST,
    idle_code: EISC_IDLE_CODE_RST
  };

  // One timeslot: data byte plus its ABCD signalling nibble
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic [3:0] abcd;
  } eisc_slot_type;

  localparam eisc_slot_type EISC_SLOT_RST = '{valid: 1'b0, data: 8'h00, abcd: 4'h0};

endpackage

//--- rtl/eisc_sync.sv
// Two-flop level synchroniser with a settable reset value
module eisc_sync
  import eisc_pkg::*;
#(
  parameter int         WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output      logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } eisc_sync_state_type;

  eisc_sync_state_type st_q;
  eisc_sync_state_type st_d;

  // Refused at elaboration: a zero-width crossing has nothing to carry
  if (WIDTH < 1)
  begin : g_bad_width
    $error("eisc_sync: WIDTH must be at least 1");
  end

  // The first stage feeds only the second stage
  always_comb
  begin
    st_d        = st_q;
    st_d.meta   = async_in;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      st_q <= '{meta: RST_VAL, stable: RST_VAL};
    else
      st_q <= st_d;
  end

  assign sync_out = st_q.stable;

endmodule // eisc_sync

//--- sim/eisc_e1_model.sv
// Behavioural E1 line equipment feeding receive timeslots and line alarms
module eisc_e1_model
  import eisc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic [2:0]    alarm_req,
  input  wire logic [7:0]    data_req,
  output      logic [2:0]    alarm,
  output      eisc_slot_type slot
);
  timeunit 1ns;
  timeprecision 100ps;

  // Changes land by non-blocking assignment on the rising edge, half a cycle after a
  // request, so the bench never races the model on the edge where it drives
  always @(posedge clk)
  begin
    alarm <= alarm_req;
    slot  <= '{valid: 1'b1, data: data_req, abcd: data_req[3:0]};
  end
endmodule // eisc_e1_model

//--- sim/tb_eisc_cond.sv
// Self-checking bench for the E1 signalling and conditioning block
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
  $display("wrong value %s exp %h got %h", nm, ex, got); mismatches++; end end
module tb_eisc_cond;
  import eisc_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic          MCLK = 1'b0, LCLK = 1'b0, RESET_N = 1'b0, CFG_LOAD = 1'b0;
  logic          BUF_OVERRUN = 1'b0, BUF_UNDERRUN = 1'b0, PKT_RX_USED = 1'b1;
  logic [2:0]    alarm_req = 3'h0, alarm;
  eisc_cfg_type  CFG_IN = EISC_CFG_RST, cfg_out, c;
  eisc_slot_type PKT_RX_SLOT = '{valid: 1'b1, data: 8'h3c, abcd: 4'h9};
  eisc_slot_type line_slot, pkt_tx, line_tx;
  logic          tx_ais, c2p, c2l, cas_mf, transp;
  int            mismatches = 0, checks = 0;

  always #4 MCLK = ~MCLK;
  // Link clock edges fall on multiples of 3 ns and meet the system clock's every 12 ns
  always #3 LCLK = ~LCLK;

  eisc_e1_model u_line (.clk(MCLK), .alarm_req(alarm_req), .data_req(8'h5a),
                        .alarm(alarm), .slot(line_slot));

  eisc_cond u_dut (.MCLK(MCLK), .RESET_N(RESET_N), .LCLK(LCLK), .CFG_LOAD(CFG_LOAD),
    .CFG_IN(CFG_IN), .LINE_LOS(alarm[0]), .LINE_LOF(alarm[1]), .LINE_AIS(alarm[2]),
    .BUF_OVERRUN(BUF_OVERRUN), .BUF_UNDERRUN(BUF_UNDERRUN), .LINE_RX_SLOT(line_slot),
    .PKT_RX_SLOT(PKT_RX_SLOT), .PKT_RX_USED(PKT_RX_USED), .PKT_TX_SLOT(pkt_tx),
    .LINE_TX_SLOT(line_tx), .LINE_TX_AIS(tx_ais), .COND_TO_PKT(c2p),
    .COND_TO_LINE(c2l), .CFG_OUT(cfg_out), .FRM_CAS_MF(cas_mf),
    .FRM_TRANSPARENT(transp));

  ////////////////////////////////////////////////////////////////////////////
  function automatic eisc_slot_type sl(input logic [7:0] d, input logic [3:0] a);
    return '{valid: 1'b1, data: d, abcd: a};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge MCLK);
  endtask

  // Extra cycles cover the registered slot outputs and the link clock crossing
  task automatic load(input eisc_cfg_type v);
    CFG_IN = v;
    CFG_LOAD = 1'b1;
    tick(1);
    CFG_LOAD = 1'b0;
    tick(6);
  endtask

  task results;
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #20000;
    mismatches++;
    results();
  end

  initial
  begin
    tick(4);
    `CHK("cfg", EISC_CFG_RST, cfg_out)
    `CHK("cas mf", 1'b1, cas_mf)
    RESET_N = 1'b1;
    tick(4);
    `CHK("pkt pass", sl(8'h5a, 4'ha), pkt_tx)
    `CHK("line pass", PKT_RX_SLOT, line_tx)
    PKT_RX_USED = 1'b0;
    tick(2);
    `CHK("idle", sl(8'h7e, 4'h9), line_tx)
    PKT_RX_USED = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      alarm_req = 3'h1 << i;
      tick(4);
      `CHK("pkt cond", sl(8'hff, 4'h1), pkt_tx)
      `CHK("cond pkt", 1'b1, c2p)
      alarm_req = 3'h0;
      tick(4);
      `CHK("pkt resume", sl(8'h5a, 4'ha), pkt_tx)
    end
    for (int i = 0; i < 2; i++)
    begin
      {BUF_UNDERRUN, BUF_OVERRUN} = 2'h1 << i;
      tick(2);
      `CHK("line cond", sl(8'hff, 4'h1), line_tx)
      `CHK("cond line", 1'b1, c2l)
      {BUF_UNDERRUN, BUF_OVERRUN} = 2'h0;
      tick(2);
      `CHK("line resume", PKT_RX_SLOT, line_tx)
    end
    c = EISC_CFG_RST;
    c.cas_en = 1'b0;
    c.cond_byte = 8'h00;
    c.cond_abcd = 4'hf;
    load(c);
    `CHK("cfg load", c, cfg_out)
    `CHK("cas off", 1'b0, cas_mf)
    `CHK("no abcd", sl(8'h5a, 4'h0), pkt_tx)
    alarm_req = 3'h1;
    tick(4);
    `CHK("cond nocas", sl(8'h00, 4'h0), pkt_tx)
    alarm_req = 3'h0;
    c.cas_en = 1'b1;
    load(c);
    alarm_req = 3'h2;
    tick(4);
    `CHK("abcd f", sl(8'h00, 4'hf), pkt_tx)
    alarm_req = 3'h0;
    c.cond_abcd = 4'h0;
    load(c);
    `CHK("abcd keep", 4'hf, cfg_out.cond_abcd)
    c.cond_abcd = 4'hf;
    c.unframed = 1'b1;
    load(c);
    `CHK("transp", 1'b1, transp)
    `CHK("mf unfr", 1'b0, cas_mf)
    BUF_OVERRUN = 1'b1;
    tick(2);
    `CHK("ais", 1'b1, tx_ais)
    `CHK("ais data", sl(8'hff, 4'h0), line_tx)
    BUF_OVERRUN = 1'b0;
    alarm_req = 3'h1;
    tick(4);
    `CHK("unfr los", sl(8'hff, 4'h0), pkt_tx)
    `CHK("ais off", 1'b0, tx_ais)
    // Reset again with a changed setup to see the defaults come back
    RESET_N = 1'b0;
    tick(2);
    `CHK("cfg rst", EISC_CFG_RST, cfg_out)
    `CHK("mf rst", 1'b1, cas_mf)
    `CHK("transp rst", 1'b0, transp)
    `CHK("ais rst", 1'b0, tx_ais)
    results();
  end
endmodule // tb_eisc_cond
